//--- rtl/cdt_core.sv
/*
 * Coprocessor data transfer unit: decodes the coprocessor load/store
 * class, checks the condition, generates every word address, handles
 * the coprocessor busy wait, aborts and base write-back.
 * Assumes the core presents the instruction with its base register
 * value and address on a start pulse, a memory side that answers an
 * access with mem_abort in the same cycle, and that data buses run
 * directly between memory and the coprocessor.
 */
`include "cdt_consts.svh"

module cdt_core (
    input  wire logic                clock,
    input  wire logic                rst,
    input  wire logic                start,          // instruction offered
    input  wire logic [31:0]         instr,          // instruction word
    input  wire logic [3:0]          flags,          // N Z C V
    input  wire logic [31:0]         base_value,     // base_register contents
    input  wire logic [31:0]         instr_addr,     // address of instruction
    input  wire logic                coproc_present, // a coprocessor is fitted
    input  wire logic                cp_busy,        // coprocessor busy wait
    input  wire logic                cp_last,        // current word is the last
    input  wire logic                mem_abort,      // abort on current access
    output cdt_pkg::cdt_cpreq_t      cp_req,         // request to coprocessor
    output logic                     unit_busy,      // instruction under way
    output logic                     mem_valid,      // memory access this cycle
    output logic [31:0]              mem_addr,       // word address
    output logic                     mem_write,      // store to memory
    output logic                     mem_seq,        // sequential access
    output cdt_pkg::cdt_cyc_t        cyc_type,       // cycle class
    output logic                     done,           // instruction finished
    output logic                     executed,       // condition passed on a word of this class
    output logic                     undef_trap,     // undefined trap
    output logic                     data_trap,      // data abort trap
    output logic                     wb_valid,       // base write-back strobe
    output logic [3:0]               wb_index,       // register written back
    output logic [31:0]              wb_value        // modified base
);

    ////////////////////////////////////////////////////////////////////
    // functions

    // split the instruction word into its fields
    function automatic cdt_pkg::cdt_dec_t cdt_decode(input logic [31:0] w);
        cdt_pkg::cdt_dec_t d;
        d.cond = w[`CDT_COND_HI:`CDT_COND_LO];
        d.pre  = w[`CDT_PRE_BIT];
        d.up   = w[`CDT_UP_BIT];
        d.len  = w[`CDT_LEN_BIT];
        d.wb   = w[`CDT_WB_BIT];
        d.load = w[`CDT_LOAD_BIT]; // RQ3
        d.rn   = w[`CDT_RN_HI:`CDT_RN_LO]; // RQ2
        d.coproc_reg_field  = w[`CDT_CRD_HI:`CDT_CRD_LO]; // RQ2
        d.cpn  = w[`CDT_CPN_HI:`CDT_CPN_LO]; // RQ2
        d.off  = w[`CDT_OFF_HI:`CDT_OFF_LO]; // RQ2
        return d;
    endfunction : cdt_decode

    // condition test against N Z C V
    function automatic logic cdt_cond_pass(input logic [3:0] c,
                                           input logic [3:0] f);
        logic n;
        logic z;
        logic cy;
        logic v;
        logic r;
        n  = f[3];
        z  = f[2];
        cy = f[1];
        v  = f[0];
        unique case (c[3:1])
            3'h0:    r = z;
            3'h1:    r = cy;
            3'h2:    r = n;
            3'h3:    r = v;
            3'h4:    r = cy & ~z;
            3'h5:    r = (n == v);
            3'h6:    r = ~z & (n == v);
            default: r = 1'b1;
        endcase
        // odd codes invert; the never code stays false
        if (c == 4'hF) begin
            cdt_cond_pass = 1'b0;
        end else begin
            cdt_cond_pass = c[0] ? ~r : r;
        end
    endfunction : cdt_cond_pass

    ////////////////////////////////////////////////////////////////////
    // state and held decode

    cdt_pkg::cdt_state_t state_reg;       // controller state
    cdt_pkg::cdt_state_t state_next;      // its next value
    cdt_pkg::cdt_dec_t   dec_reg;         // fields of the held instruction
    logic [31:0]         mod_reg;         // offset-modified base
    logic                abort_reg;       // an access was aborted

    ////////////////////////////////////////////////////////////////////
    // combinational decode of the offered word

    cdt_pkg::cdt_dec_t dec_in;            // fields of the offered word
    logic [31:0]       base_eff;          // base after pc correction
    logic [31:0]       off_bytes;         // offset in bytes
    logic [31:0]       mod_base;          // base with offset applied
    logic [31:0]       first_addr;        // address of the first word
    logic              accept;            // start taken this cycle
    logic              in_class;          // word is of this class
    logic              cond_ok;           // condition passed
    logic              go_xfer;           // begin a real transfer
    logic              go_undef;          // no coprocessor, trap

    always_comb begin
        dec_in     = cdt_decode(instr);
        // pc as base reads ahead by the pipeline distance
        base_eff   = (dec_in.rn == `CDT_PC_INDEX) ? instr_addr + `CDT_PC_AHEAD
                                                  : base_value; // RQ13
        off_bytes  = {22'h000000, dec_in.off, 2'h0}; // RQ7
        mod_base   = dec_in.up ? base_eff + off_bytes
                               : base_eff - off_bytes; // RQ7
        first_addr = dec_in.pre ? mod_base : base_eff; // RQ8 RQ11
        accept     = start && (state_reg == cdt_pkg::CDT_IDLE);
        in_class   = (instr[`CDT_CLASS_HI:`CDT_CLASS_LO] == `CDT_CLASS_PAT); // RQ19
        cond_ok    = cdt_cond_pass(dec_in.cond, flags); // RQ1
        go_xfer    = accept && in_class && cond_ok && coproc_present;
        go_undef   = accept && in_class && cond_ok && !coproc_present; // RQ18
    end

    ////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            cdt_pkg::CDT_IDLE: begin
                // a busy coprocessor holds off the first access
                if (go_xfer) begin
                    state_next = cp_busy ? cdt_pkg::CDT_WAIT
                                         : cdt_pkg::CDT_XFER;
                end
            end
            cdt_pkg::CDT_WAIT: begin
                if (!cp_busy) begin
                    state_next = cdt_pkg::CDT_XFER;
                end
            end
            cdt_pkg::CDT_XFER: begin
                // coprocessor ends the run; an abort ends it early
                if (mem_abort || cp_last) begin
                    state_next = cdt_pkg::CDT_FIN; // RQ4 RQ15
                end
            end
            cdt_pkg::CDT_FIN: begin
                state_next = cdt_pkg::CDT_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= cdt_pkg::CDT_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // hold fields and modified base for the whole instruction
    always_ff @(posedge clock) begin
        if (rst) begin
            dec_reg <= '0;
            mod_reg <= 32'h0000_0000;
        end else if (go_xfer) begin
            dec_reg <= dec_in;
            mod_reg <= mod_base;
        end
    end

    // abort memory, cleared at each new transfer
    always_ff @(posedge clock) begin
        if (rst) begin
            abort_reg <= 1'b0;
        end else if (go_xfer) begin
            abort_reg <= 1'b0;
        end else if (state_reg == cdt_pkg::CDT_XFER && mem_abort) begin
            abort_reg <= 1'b1; // RQ15
        end
    end

    ////////////////////////////////////////////////////////////////////
    // memory side

    always_ff @(posedge clock) begin
        if (rst) begin
            mem_valid <= 1'b0;
            mem_addr  <= 32'h0000_0000;
            mem_write <= 1'b0;
            mem_seq   <= 1'b0;
        end else begin
            unique case (state_next)
                cdt_pkg::CDT_XFER: begin
                    mem_valid <= 1'b1;
                    if (state_reg == cdt_pkg::CDT_XFER) begin
                        // later words climb one word; low bits kept as is
                        mem_addr <= mem_addr + `CDT_WORD_STEP; // RQ11 RQ12
                        mem_seq  <= 1'b1;
                    end else begin
                        mem_seq <= 1'b0;
                    end
                end
                default: begin
                    mem_valid <= 1'b0;
                    mem_seq   <= 1'b0;
                end
            endcase
            // first address loaded at acceptance, unmasked
            if (go_xfer) begin
                mem_addr  <= first_addr; // RQ4 RQ12
                mem_write <= !dec_in.load; // RQ3
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // coprocessor side: fields passed on uninterpreted

    always_ff @(posedge clock) begin
        if (rst) begin
            cp_req    <= '0;
            unit_busy <= 1'b0;
        end else begin
            if (go_xfer) begin
                cp_req.id     <= dec_in.cpn; // RQ5
                cp_req.creg   <= dec_in.coproc_reg_field; // RQ6
                cp_req.long_x <= dec_in.len; // RQ6
                cp_req.load   <= dec_in.load; // RQ3
            end
            cp_req.active <= (state_next == cdt_pkg::CDT_WAIT)
                          || (state_next == cdt_pkg::CDT_XFER);
            unit_busy     <= (state_next != cdt_pkg::CDT_IDLE);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // cycle class: busy wait is internal, first and last non-sequential

    always_ff @(posedge clock) begin
        if (rst) begin
            cyc_type <= cdt_pkg::CDT_CYC_NONE;
        end else begin
            unique case (state_next)
                cdt_pkg::CDT_WAIT: cyc_type <= cdt_pkg::CDT_CYC_I; // RQ17
                cdt_pkg::CDT_XFER: begin
                    cyc_type <= (state_reg == cdt_pkg::CDT_XFER)
                              ? cdt_pkg::CDT_CYC_S
                              : cdt_pkg::CDT_CYC_N; // RQ17
                end
                cdt_pkg::CDT_FIN:  cyc_type <= cdt_pkg::CDT_CYC_N; // RQ17
                default:           cyc_type <= cdt_pkg::CDT_CYC_NONE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // completion, traps and base write-back

    always_ff @(posedge clock) begin
        if (rst) begin
            done       <= 1'b0;
            executed   <= 1'b0;
            undef_trap <= 1'b0;
            data_trap  <= 1'b0;
            wb_valid   <= 1'b0;
            wb_index   <= 4'h0;
            wb_value   <= 32'h0000_0000;
        end else begin
            // pulses by default
            done       <= 1'b0;
            undef_trap <= 1'b0;
            data_trap  <= 1'b0;
            wb_valid   <= 1'b0;
            if (accept && !(in_class && cond_ok)) begin
                // failed condition or foreign word: no effect at all
                done     <= 1'b1; // RQ1
                executed <= 1'b0;
            end else if (go_undef) begin
                // without a coprocessor software emulates the transfer
                done       <= 1'b1;
                executed   <= 1'b1;
                undef_trap <= 1'b1; // RQ18
            end else if (state_reg == cdt_pkg::CDT_FIN) begin
                done      <= 1'b1;
                executed  <= 1'b1;
                data_trap <= abort_reg; // RQ15
                // write-back only on explicit request, also on abort;
                // a pc base is never overwritten
                wb_valid  <= dec_reg.wb
                          && (dec_reg.rn != `CDT_PC_INDEX); // RQ9 RQ10 RQ14 RQ15
                wb_index  <= dec_reg.rn;
                wb_value  <= mod_reg; // RQ9
            end
        end
    end

endmodule : cdt_core

//--- shared/cdt_consts.svh
/*
 * Constants of the coprocessor data transfer unit: instruction field
 * positions, class pattern, address arithmetic figures.
 * Assumes it is included by bare name wherever these figures are needed.
 */
// Function
// RQ1: execute only when condition field passes
// RQ2: decode offset, coprocessor number, register, base
// RQ3: bit 20 one loads, zero stores
// RQ4: core makes addresses, coprocessor moves data, count
// RQ5: coprocessor answers only its own number
// RQ6: coprocessor interprets length bit, register field
// RQ7: offset times four, added or subtracted
// RQ8: pre-index applies offset before use
// RQ9: write-back bit stores modified base
// RQ10: post-index never writes back implicitly
// RQ11: first word base, then four bytes up
// RQ12: low two address bits pass unmasked
// RQ13: program counter base reads instruction plus eight
// RQ14: never write back into program counter
// RQ15: abort takes data trap, still writes back
// RQ16: coprocessor keeps transfer restartable after abort
// RQ17: cost (n-1) sequential, two non-sequential, busy internal
// RQ18: no coprocessor fitted raises undefined trap
// RQ19: class recognised by bits 27:25 equal 110
`ifndef CDT_CONSTS_SVH
`define CDT_CONSTS_SVH

// field positions in the instruction word
`define CDT_COND_HI    31
`define CDT_COND_LO    28
`define CDT_CLASS_HI   27
`define CDT_CLASS_LO   25
`define CDT_PRE_BIT    24
`define CDT_UP_BIT     23
`define CDT_LEN_BIT    22
`define CDT_WB_BIT     21
`define CDT_LOAD_BIT   20
`define CDT_RN_HI      19
`define CDT_RN_LO      16
`define CDT_CRD_HI     15
`define CDT_CRD_LO     12
`define CDT_CPN_HI     11
`define CDT_CPN_LO     8
`define CDT_OFF_HI     7
`define CDT_OFF_LO     0

// class pattern and address figures
`define CDT_CLASS_PAT  3'h6
`define CDT_PC_INDEX   4'hF
`define CDT_PC_AHEAD   32'h0000_0008
`define CDT_WORD_STEP  32'h0000_0004

`endif

//--- shared/cdt_pkg.sv
/*
 * Types of the coprocessor data transfer unit.
 * Assumes cdt_consts.svh is compiled alongside.
 */
package cdt_pkg;

    // decoded instruction fields
    typedef struct packed {
        logic [3:0] cond;   // condition code
        logic       pre;    // pre-index
        logic       up;     // add offset
        logic       len;    // length option, coprocessor's own
        logic       wb;     // write-back
        logic       load;   // memory to coprocessor
        logic [3:0] rn;     // base register index
        logic [3:0] coproc_reg_field;    // coprocessor register
        logic [3:0] cpn;    // coprocessor number
        logic [7:0] off;    // word offset
    } cdt_dec_t;

    // request shown to the coprocessor
    typedef struct packed {
        logic       active; // transfer under way
        logic [3:0] id;     // coproc_id_field
        logic [3:0] creg;   // coproc_reg_field
        logic       long_x; // length option
        logic       load;   // coproc_memory_read when set
    } cdt_cpreq_t;

    // controller states, gray along the path through CDT_WAIT; IDLE to XFER flips both bits
    typedef enum logic [1:0] {
        CDT_IDLE = 2'h0,
        CDT_WAIT = 2'h1,
        CDT_XFER = 2'h3,
        CDT_FIN  = 2'h2
    } cdt_state_t;

    // bus cycle class of the current cycle
    typedef enum logic [1:0] {
        CDT_CYC_NONE = 2'h0,
        CDT_CYC_N    = 2'h1,
        CDT_CYC_S    = 2'h2,
        CDT_CYC_I    = 2'h3
    } cdt_cyc_t;

endpackage : cdt_pkg

//--- sim/cdt_asserts.sv
/*
 * Port checker of the coprocessor data transfer unit.
 * Assumes it is bound onto cdt_core and that one clock drives it all.
 */
module cdt_asserts (
    input wire logic                clock,
    input wire logic                rst,
    input wire logic                start,
    input wire logic [31:0]         instr,
    input wire logic                coproc_present,
    input wire logic                cp_last,
    input wire logic                mem_abort,
    input wire cdt_pkg::cdt_cpreq_t cp_req,
    input wire logic                unit_busy,
    input wire logic                mem_valid,
    input wire logic [31:0]         mem_addr,
    input wire logic                mem_write,
    input wire logic                mem_seq,
    input wire cdt_pkg::cdt_cyc_t   cyc_type,
    input wire logic                done,
    input wire logic                executed,
    input wire logic                undef_trap,
    input wire logic                data_trap,
    input wire logic                wb_valid,
    input wire logic [3:0]          wb_index
);
    // one domain, so clock and reset are given once
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////
    // skip, trap and decode outcomes one cycle after accept
    a_cond_never: assert property (start && !unit_busy && instr[31:28] == 4'hF
        |=> done && !executed && !mem_valid) else $error("never-code executed");
    a_class_skip: assert property (start && !unit_busy && instr[27:25] != 3'h6
        |=> done && !executed && !undef_trap) else $error("foreign class executed");
    a_undef_trap: assert property (start && !unit_busy && !coproc_present
        && instr[27:25] == 3'h6 && instr[31:28] == 4'hE |=> done && undef_trap && !mem_valid)
        else $error("no undefined trap");

    ////////////////////////////////////////////////////////////
    // word stream: direction, stepping, cycle classes, endings
    a_dir_bit: assert property (mem_valid |-> mem_write == !cp_req.load)
        else $error("direction wrong");
    a_word_step: assert property (mem_valid && $past(mem_valid) |-> mem_seq
        && cyc_type == cdt_pkg::CDT_CYC_S && mem_addr == $past(mem_addr) + 32'h0000_0004)
        else $error("word step wrong");
    a_first_nseq: assert property ($rose(mem_valid) |-> !mem_seq
        && cyc_type == cdt_pkg::CDT_CYC_N) else $error("first word not N");
    a_last_word: assert property (mem_valid && cp_last && !mem_abort
        |=> !mem_valid ##1 done && !data_trap) else $error("count not obeyed");
    a_abort_stop: assert property (mem_valid && mem_abort
        |=> !mem_valid ##1 done && data_trap) else $error("abort not taken");
    a_pc_no_wb: assert property (wb_valid |-> done && wb_index != 4'hF)
        else $error("bad write-back");
    a_busy_span: assert property (mem_valid |-> unit_busy && cp_req.active)
        else $error("word outside busy span");
endmodule : cdt_asserts

bind cdt_core cdt_asserts u_chk (.clock(clock), .rst(rst), .start(start), .instr(instr),
    .coproc_present(coproc_present), .cp_last(cp_last), .mem_abort(mem_abort),
    .cp_req(cp_req), .unit_busy(unit_busy), .mem_valid(mem_valid), .mem_addr(mem_addr),
    .mem_write(mem_write), .mem_seq(mem_seq), .cyc_type(cyc_type), .done(done),
    .executed(executed), .undef_trap(undef_trap), .data_trap(data_trap),
    .wb_valid(wb_valid), .wb_index(wb_index));

//--- sim/cdt_cp_model.sv
/*
 * Behavioural coprocessor and memory abort source.
 * Assumes the bench sets busy length, word count and abort word between runs.
 */
module cdt_cp_model (
    input  wire logic                clock,
    input  wire logic                rst,
    input  wire cdt_pkg::cdt_cpreq_t cp_req,
    input  wire logic                mem_valid,
    input  wire logic [3:0]          own_id,
    input  wire logic [7:0]          busy_n,
    input  wire logic [7:0]          n_words,
    input  wire logic [7:0]          abort_at,
    output logic                     cp_busy,
    output logic                     cp_last,
    output logic                     mem_abort
);
    logic [7:0] bc_reg;  // edges seen while active
    logic [7:0] wc_reg;  // words already passed
    logic       tgl_reg; // junk shown on released lines
    logic       hit;     // request carries our number

    assign hit = (cp_req.id == own_id);

    ////////////////////////////////////////////////////////////
    // counters restart whenever idle, so a retry repeats exactly
    always_ff @(posedge clock) begin
        if (rst || !cp_req.active) begin
            bc_reg <= 8'h00;
            wc_reg <= 8'h00;
        end else begin
            bc_reg <= bc_reg + 8'h01;
            wc_reg <= wc_reg + {7'h00, mem_valid};
        end
        tgl_reg <= rst ? 1'b0 : ~tgl_reg;
    end

    // busy at accept edge counts as the first wait cycle
    assign cp_busy   = cp_req.active ? (hit && bc_reg + 8'h01 < busy_n) : (busy_n != 8'h00);
    // word count decided here, not by the core
    assign cp_last   = mem_valid ? (hit && wc_reg == n_words - 8'h01) : tgl_reg;
    assign mem_abort = mem_valid ? (wc_reg == abort_at) : ~tgl_reg;
endmodule : cdt_cp_model

//--- sim/testbench.sv
/*
 * Self-checking bench of the coprocessor data transfer unit.
 * Assumes cdt_pkg, cdt_core, the checker and cdt_cp_model are compiled first.
 */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 1'b0, rst = 1'b1, start = 1'b0, coproc_present = 1'b1;
    logic [31:0] instr = 32'h0, base_value = 32'h0, instr_addr = 32'h0;
    logic [3:0]  flags = 4'h0;
    logic [7:0]  busy_n = 8'h00, n_words = 8'h01, abort_at = 8'hFF;
    logic        cp_busy, cp_last, mem_abort, unit_busy, mem_valid, mem_write, mem_seq;
    logic        done, executed, undef_trap, data_trap, wb_valid, wr;
    logic [3:0]  wb_index;
    logic [31:0] mem_addr, wb_value;
    logic [31:0] addr [8];   // word addresses seen
    cdt_pkg::cdt_cpreq_t cp_req;
    cdt_pkg::cdt_cyc_t   cyc_type;
    int na, nn, ns, ni, mismatches = 0, n_compared = 0, cyc = 0;

    cdt_core dut (.clock(clock), .rst(rst), .start(start), .instr(instr), .flags(flags),
        .base_value(base_value), .instr_addr(instr_addr), .coproc_present(coproc_present),
        .cp_busy(cp_busy), .cp_last(cp_last), .mem_abort(mem_abort), .cp_req(cp_req),
        .unit_busy(unit_busy), .mem_valid(mem_valid), .mem_addr(mem_addr),
        .mem_write(mem_write), .mem_seq(mem_seq), .cyc_type(cyc_type), .done(done),
        .executed(executed), .undef_trap(undef_trap), .data_trap(data_trap),
        .wb_valid(wb_valid), .wb_index(wb_index), .wb_value(wb_value));
    cdt_cp_model cop (.clock(clock), .rst(rst), .cp_req(cp_req), .mem_valid(mem_valid),
        .own_id(4'h5), .busy_n(busy_n), .n_words(n_words), .abort_at(abort_at),
        .cp_busy(cp_busy), .cp_last(cp_last), .mem_abort(mem_abort));

    always #12.5 clock = ~clock;

    // hang guard, far above the few hundred cycles needed
    always @(posedge clock) begin
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    ////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        if (mismatches == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic ok, input string m);
        n_compared++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask : chk

    // coprocessor 5, register 10, long option set
    function automatic logic [31:0] mk(input logic [3:0] c, input logic [2:0] puw,
        input logic l, input logic [3:0] rn, input logic [7:0] off);
        return {c, 3'h6, puw[2], puw[1], 1'b1, puw[0], l, rn, 4'hA, 4'h5, off};
    endfunction : mk

    // condition table indexed by code, flags {n,z,c,v}
    function automatic logic pass(input logic [3:0] c, input logic [3:0] f);
        logic        n, z, cr, v;
        logic [15:0] t;  // one outcome bit per code
        {n, z, cr, v} = f;
        t = {1'b0, 1'b1, z | (n ^ v), ~z & ~(n ^ v), n ^ v, ~(n ^ v), ~cr | z, cr & ~z,
            ~v, v, ~n, n, ~cr, cr, ~z, z};
        return t[c];
    endfunction : pass

    // offer one instruction, log words and cycle classes until done
    task automatic run(input logic [31:0] ins, input logic [31:0] b, input logic [3:0] f);
        int k;
        start = 1'b1;
        instr = ins;
        base_value = b;
        instr_addr = 32'h0000_2000;
        flags = f;
        na = 0;
        nn = 0;
        ns = 0;
        ni = 0;
        @(negedge clock);
        start = 1'b0;
        for (k = 0; k < 60 && done !== 1'b1; k++) begin
            if (mem_valid === 1'b1) begin
                addr[na % 8] = mem_addr;
                wr = mem_write;
                na++;
            end
            nn += int'(cyc_type === cdt_pkg::CDT_CYC_N);
            ns += int'(cyc_type === cdt_pkg::CDT_CYC_S);
            ni += int'(cyc_type === cdt_pkg::CDT_CYC_I);
            @(negedge clock);
        end
        chk(done === 1'b1, "done missing");
    endtask : run

    ////////////////////////////////////////////////////////////
    // all indexing modes, unaligned base, busy waits of 0..2
    task automatic s_modes;
        logic [31:0] e;
        logic        l;
        int          m;
        for (m = 0; m < 8; m++) begin
            busy_n = 8'(m % 3);
            n_words = 8'h02;
            l = m[1] ^ m[0];
            run(mk(4'hE, m[2:0], l, 4'h3, 8'h21), 32'h0000_1001, 4'h0);
            e = m[1] ? 32'h0000_1085 : 32'h0000_0F7D;
            chk(addr[0] === (m[2] ? e : 32'h0000_1001), "first address");
            chk(addr[1] === addr[0] + 32'h4 && na == 2, "second address");
            chk(wb_valid === m[0] && (!m[0] || wb_value === e), "write-back");
            chk(wb_index === 4'h3 && wr === ~l && cp_req.id === 4'h5, "fields");
            chk(cp_req.load === l && cp_req.long_x === 1'b1, "request fields");
            chk(cp_req.creg === 4'hA && nn == 2 && ns == 1 && ni == m % 3, "cost");
        end
        busy_n = 8'h00;
    endtask : s_modes

    task automatic s_pc;
        n_words = 8'h04;
        run(mk(4'hE, 3'h7, 1'b1, 4'hF, 8'h02), 32'hDEAD_0000, 4'h0);
        chk(addr[0] === 32'h0000_2010 && na == 4, "pc base");
        chk(addr[3] === 32'h0000_201C && ns == 3, "last word");
        chk(wb_valid === 1'b0, "pc write-back");
    endtask : s_pc

    task automatic s_abort;
        n_words = 8'h03;
        abort_at = 8'h01;
        // length option cleared here, so the request must show the short form
        run(mk(4'hE, 3'h5, 1'b0, 4'h7, 8'h01) ^ 32'h0040_0000, 32'h0000_0100, 4'h0);
        abort_at = 8'hFF;
        chk(cp_req.long_x === 1'b0 && cp_req.creg === 4'hA, "short option");
        chk(na == 2 && data_trap === 1'b1, "abort");
        chk(wb_valid === 1'b1 && wb_value === 32'h0000_00FC, "abort write-back");
    endtask : s_abort

    task automatic s_cond;
        logic [3:0] ft [3] = '{4'h2, 4'hD, 4'h8};
        logic       e;
        int         k;
        n_words = 8'h01;
        for (k = 0; k < 48; k++) begin
            run(mk(4'(k), 3'h4, 1'b1, 4'h1, 8'h00), 32'h40, ft[k / 16]);
            e = pass(4'(k), ft[k / 16]);
            chk(executed === e && na == (e ? 1 : 0), "condition");
        end
    endtask : s_cond

    task automatic s_undef;
        coproc_present = 1'b0;
        run(mk(4'hE, 3'h4, 1'b0, 4'h2, 8'h00), 32'h80, 4'h0);
        coproc_present = 1'b1;
        chk(undef_trap === 1'b1 && executed === 1'b1 && na == 0, "undefined");
    endtask : s_undef

    task automatic s_class;
        run(mk(4'hE, 3'h4, 1'b0, 4'h2, 8'h00) ^ 32'h0200_0000, 32'h80, 4'h0);
        chk(executed === 1'b0 && undef_trap === 1'b0 && na == 0, "class");
    endtask : s_class

    ////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(negedge clock);
        rst = 1'b0;
        s_modes();
        s_pc();
        s_abort();
        s_cond();
        s_undef();
        s_class();
        tally_and_finish();
    end
endmodule : testbench
